// File: src/portable_cipher_ctl.sv
// portable-end cipher mode controller: handshake, generator load, keying
// assumes frame counters synchronous to clock; generator external
`timescale 1ns/1ps
`include "cipher_ctl_regs.svh"
module portable_cipher_ctl (
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [`KEY_W-1:0] cipher_key,
  input wire logic frame_start,
  input wire logic [`IV_FRAME_W-1:0] frame_num,
  input wire logic [`IV_MFRAME_W-1:0] mframe_num,
  input wire logic switch_mode_request,
  output logic switch_mode_confirm,
  output logic disconnect_indication,
  output logic cipher_mode,
  output logic [`MSG_W-1:0] tx_tail_msg,
  input wire logic [`MSG_W-1:0] rx_tail_msg,
  input wire logic rx_tail_valid,
  output cipher_ctl_pkg::ksg_load_t ksg_load,
  output logic ksg_load_valid,
  input wire logic ks_bit,
  input wire logic ks_valid,
  output logic ks_ready,
  input wire logic rx_is_ct,
  input wire logic tx_is_ct,
  input wire cipher_ctl_pkg::slot_word_t rx_in,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  output cipher_ctl_pkg::slot_word_t rx_out,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  input wire cipher_ctl_pkg::slot_word_t tx_in,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  output cipher_ctl_pkg::slot_word_t tx_out,
  output logic tx_out_valid,
  input wire logic tx_out_ready
);
  ////////////////////////////////////////////////////////////////////////
  // mode handshake
  cipher_ctl_pkg::mode_state_t st_q;
  cipher_ctl_pkg::mode_state_t st_d;
  logic [`TRY_W-1:0] tries_q;
  logic rx_cipher_q;
  logic tx_cipher_q;
  logic drop_rx_q;
  logic cfm_q;
  logic dis_q;
  logic [`MSG_W-1:0] msg_q;
  wire even_frame = ~frame_num[0];
  // even-frame slot is the only chance to send our tail message
  wire our_slot = frame_start && even_frame;
  wire got_on_conf = rx_tail_valid && rx_tail_msg == `MSG_ON_CONF;
  wire got_off_conf = rx_tail_valid && rx_tail_msg == `MSG_OFF_CONF;
  wire tries_out = tries_q == `REQ_TRIES;
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      // only the local request starts a switch
      cipher_ctl_pkg::ST_CLEAR:
        if (switch_mode_request) st_d = cipher_ctl_pkg::ST_ON_REQ;
      cipher_ctl_pkg::ST_ON_REQ:
        if (got_on_conf) st_d = cipher_ctl_pkg::ST_ON_GRANT;
        else if (our_slot && tries_out)
          st_d = cipher_ctl_pkg::ST_RELEASED;
      cipher_ctl_pkg::ST_ON_GRANT:
        if (our_slot) st_d = cipher_ctl_pkg::ST_CIPHER;
      cipher_ctl_pkg::ST_CIPHER:
        if (switch_mode_request) st_d = cipher_ctl_pkg::ST_OFF_REQ;
      cipher_ctl_pkg::ST_OFF_REQ:
        if (got_off_conf) st_d = cipher_ctl_pkg::ST_OFF_GRANT;
        else if (our_slot && tries_out)
          st_d = cipher_ctl_pkg::ST_RELEASED;
      cipher_ctl_pkg::ST_OFF_GRANT:
        if (our_slot) st_d = cipher_ctl_pkg::ST_CLEAR;
      cipher_ctl_pkg::ST_RELEASED:
        st_d = cipher_ctl_pkg::ST_RELEASED;
      default:
        st_d = cipher_ctl_pkg::ST_CLEAR;
    endcase
  end
  wire in_req = st_q == cipher_ctl_pkg::ST_ON_REQ ||
    st_q == cipher_ctl_pkg::ST_OFF_REQ;
  wire req_msg_sent = in_req && our_slot && !tries_out;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      st_q <= cipher_ctl_pkg::ST_CLEAR;
      tries_q <= '0;
      rx_cipher_q <= 1'b0;
      tx_cipher_q <= 1'b0;
      drop_rx_q <= 1'b0;
      cfm_q <= 1'b0;
      dis_q <= 1'b0;
      msg_q <= `MSG_NONE;
    end
    else if (enable)
    begin
      st_q <= st_d;
      cfm_q <= 1'b0;
      dis_q <= 1'b0;
      if (st_d != st_q && !in_req) tries_q <= '0;
      else if (req_msg_sent) tries_q <= tries_q + 3'h1;
      // first request sent opens the drop window
      if (req_msg_sent && tries_q == '0) drop_rx_q <= 1'b1;
      if (got_on_conf && st_q == cipher_ctl_pkg::ST_ON_REQ)
      begin
        rx_cipher_q <= 1'b1;
        drop_rx_q <= 1'b0;
        cfm_q <= 1'b1;
      end
      if (got_off_conf && st_q == cipher_ctl_pkg::ST_OFF_REQ)
      begin
        rx_cipher_q <= 1'b0;
        drop_rx_q <= 1'b0;
        cfm_q <= 1'b1;
      end
      if (st_d == cipher_ctl_pkg::ST_RELEASED &&
          st_q != cipher_ctl_pkg::ST_RELEASED)
        dis_q <= 1'b1;
      if (st_q == cipher_ctl_pkg::ST_ON_GRANT && our_slot)
        tx_cipher_q <= 1'b1;
      if (st_q == cipher_ctl_pkg::ST_OFF_GRANT && our_slot)
        tx_cipher_q <= 1'b0;
      if (frame_start)
      begin
        if (!even_frame) msg_q <= `MSG_NONE;
        else
          case (st_q)
            cipher_ctl_pkg::ST_ON_REQ:
              msg_q <= tries_out ? `MSG_NONE : `MSG_ON_REQ;
            cipher_ctl_pkg::ST_ON_GRANT: msg_q <= `MSG_ON_GRANT;
            cipher_ctl_pkg::ST_OFF_REQ:
              msg_q <= tries_out ? `MSG_NONE : `MSG_OFF_REQ;
            cipher_ctl_pkg::ST_OFF_GRANT: msg_q <= `MSG_OFF_GRANT;
            default: msg_q <= `MSG_NONE;
          endcase
      end
    end
  assign switch_mode_confirm = cfm_q;
  assign disconnect_indication = dis_q;
  // one mode flag for the connection, high while rx_cipher_q or tx_cipher_q is set
  assign cipher_mode = tx_cipher_q | rx_cipher_q;
  // tail messages bypass the cipher path entirely
  assign tx_tail_msg = msg_q;
  ////////////////////////////////////////////////////////////////////////
  // generator load per frame
  cipher_ctl_pkg::ksg_load_t load_q;
  logic load_v_q;
  function automatic logic [`IV_W-1:0] make_iv(
    input logic [`IV_FRAME_W-1:0] f,
    input logic [`IV_MFRAME_W-1:0] m
  );
    make_iv = {{`IV_PAD_W{1'b0}}, m, f};
  endfunction
  wire need_ks = cipher_mode || in_req ||
    st_q == cipher_ctl_pkg::ST_ON_GRANT;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      load_q <= '0;
      load_v_q <= 1'b0;
    end
    else if (enable)
    begin
      load_v_q <= frame_start && need_ks;
      if (frame_start)
      begin
        load_q.cipher_key <= cipher_key;
        load_q.init_value <= make_iv(frame_num, mframe_num);
      end
    end
  assign ksg_load = load_q;
  assign ksg_load_valid = load_v_q;
  ////////////////////////////////////////////////////////////////////////
  // keystream split into the two segments
  logic in_second;
  logic in_tail;
  logic pair_done;
  wire rxb_ready;
  wire txb_ready;
  segment_splitter u_split (
    .clock(clock),
    .nrst(nrst),
    .enable(enable),
    .restart(load_v_q),
    .ks_valid(ks_valid && ks_ready),
    .in_second(in_second),
    .in_tail(in_tail),
    .pair_done(pair_done)
  );
  // first segment feeds receive, second feeds transmit
  // clear mode has no keystream; gating it there would stall transmit
  wire rx_open = !need_ks || (!in_second && ks_valid);
  wire tx_open = !need_ks || (in_second && ks_valid);
  wire rx_take = rx_open && rx_in_valid && rxb_ready;
  wire tx_take = tx_open && tx_in_valid && txb_ready;
  // the bitwise cipher consumes one key bit per data word lane bit 0
  assign ks_ready = need_ks && !pair_done && (rx_take || tx_take);
  function automatic logic [`WORD_W-1:0] apply_ks(
    input logic [`WORD_W-1:0] d,
    input logic k,
    input logic on,
    input logic tail,
    input logic ct
  );
    // tail bits only when control-channel, payload always
    apply_ks = d ^ {{(`WORD_W-1){1'b0}},
      k & on & (!tail | ct)};
  endfunction
  cipher_ctl_pkg::slot_word_t rx_mix;
  cipher_ctl_pkg::slot_word_t tx_mix;
  always_comb
  begin
    rx_mix = rx_in;
    rx_mix.data = apply_ks(rx_in.data, ks_bit, rx_cipher_q || got_on_conf,
      in_tail, rx_is_ct);
    rx_mix.discard = rx_in.discard | (drop_rx_q && !got_on_conf &&
      !got_off_conf);
    tx_mix = tx_in;
    tx_mix.data = apply_ks(tx_in.data, ks_bit, tx_cipher_q ||
      (st_q == cipher_ctl_pkg::ST_ON_GRANT), in_tail, tx_is_ct);
  end
  ////////////////////////////////////////////////////////////////////////
  // output buffers
  word_skid_buffer #(.W($bits(cipher_ctl_pkg::slot_word_t))) u_rxbuf (
    .clock(clock),
    .nrst(nrst),
    .enable(enable),
    .in_data(rx_mix),
    .in_valid(rx_in_valid && rx_open),
    .in_ready(rxb_ready),
    .out_data(rx_out),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready)
  );
  word_skid_buffer #(.W($bits(cipher_ctl_pkg::slot_word_t))) u_txbuf (
    .clock(clock),
    .nrst(nrst),
    .enable(enable),
    .in_data(tx_mix),
    .in_valid(tx_in_valid && tx_open),
    .in_ready(txb_ready),
    .out_data(tx_out),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready)
  );
  assign rx_in_ready = rxb_ready && rx_open;
  assign tx_in_ready = txb_ready && tx_open;
  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_START_CLEAR: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(nrst) |-> !cipher_mode)
    else $error("not clear at start");
  AST_MSG_EVEN: assert property (
    @(posedge clock) disable iff (!nrst)
    tx_tail_msg != `MSG_NONE |-> ~frame_num[0] || !$stable(frame_num))
    else $error("message outside even frame");
  AST_TRIES: assert property (
    @(posedge clock) disable iff (!nrst)
    tries_q <= `REQ_TRIES)
    else $error("too many requests");
  AST_DIS_PULSE: assert property (
    @(posedge clock) disable iff (!nrst)
    disconnect_indication |=> !disconnect_indication)
    else $error("disconnect not a pulse");
  AST_IV_PAD: assert property (
    @(posedge clock) disable iff (!nrst)
    ksg_load_valid |->
      ksg_load.init_value[`IV_W-1:`IV_MFRAME_LSB+`IV_MFRAME_W] == '0)
    else $error("init value pad nonzero");
  // a load must come from the frame that has just started
  AST_IV_FRAME: assert property (
    @(posedge clock) disable iff (!nrst)
    (ksg_load_valid && $past(enable)) |-> $past(frame_start) &&
      ksg_load.init_value[`IV_FRAME_LSB+`IV_FRAME_W-1:`IV_FRAME_LSB] ==
      $past(frame_num))
    else $error("load not from this frame");
  AST_GRANT_TX: assert property (
    @(posedge clock) disable iff (!nrst)
    (enable && st_q == cipher_ctl_pkg::ST_ON_GRANT && our_slot)
    |=> tx_cipher_q)
    else $error("tx not ciphered at grant");
  AST_STOP_TX: assert property (
    @(posedge clock) disable iff (!nrst)
    (enable && st_q == cipher_ctl_pkg::ST_OFF_GRANT && our_slot)
    |=> !tx_cipher_q)
    else $error("tx ciphered after stop");
  AST_CONF_RX: assert property (
    @(posedge clock) disable iff (!nrst)
    (enable && got_on_conf && st_q == cipher_ctl_pkg::ST_ON_REQ)
    |=> rx_cipher_q && switch_mode_confirm)
    else $error("confirm not taken");
  // received words may only use the first segment of the pair
  AST_RX_FIRST: assert property (
    @(posedge clock) disable iff (!nrst)
    (need_ks && rx_in_valid && rx_in_ready) |-> !in_second && ks_ready)
    else $error("receive word outside first segment");
  COV_ON: cover property (@(posedge clock) $rose(tx_cipher_q));
  COV_OFF: cover property (@(posedge clock) $fell(tx_cipher_q));
  COV_DIS: cover property (@(posedge clock) disconnect_indication);
  COV_CONF: cover property (@(posedge clock) switch_mode_confirm);
endmodule // portable_cipher_ctl

// File: src/cipher_ctl_regs.svh
// constants of the portable-end cipher mode controller
// assumes inclusion by bare name from src/
`ifndef CIPHER_CTL_REGS_SVH
`define CIPHER_CTL_REGS_SVH
`define KEY_W 64
`define IV_W 35
`define IV_FRAME_LSB 0
`define IV_FRAME_W 4
`define IV_MFRAME_LSB 4
`define IV_MFRAME_W 24
`define IV_PAD_W 7
`define SEG_BITS 360
`define PAIR_BITS 720
`define TAIL_BITS 40
`define PAYLOAD_BITS 320
`define REQ_TRIES 3'h5
`define TRY_W 3
`define WORD_W 8
`define MSG_W 3
`define MSG_NONE 3'h0
`define MSG_ON_REQ 3'h1
`define MSG_ON_CONF 3'h2
`define MSG_ON_GRANT 3'h3
`define MSG_OFF_REQ 3'h4
`define MSG_OFF_CONF 3'h5
`define MSG_OFF_GRANT 3'h6
`endif

// File: src/cipher_ctl_pkg.sv
// types of the portable-end cipher mode controller
// assumes the constants header is on the include path
`include "cipher_ctl_regs.svh"
package cipher_ctl_pkg;
  typedef enum logic [2:0] {
    ST_CLEAR = 3'h0,
    ST_ON_REQ = 3'h1,
    ST_ON_GRANT = 3'h2,
    ST_CIPHER = 3'h3,
    ST_OFF_REQ = 3'h4,
    ST_OFF_GRANT = 3'h5,
    ST_RELEASED = 3'h6
  } mode_state_t;
  // one word of slot data with its last and discard flags
  typedef struct packed {
    logic [`WORD_W-1:0] data;
    logic last;
    logic discard;
  } slot_word_t;
  // generator load request
  typedef struct packed {
    logic [`KEY_W-1:0] cipher_key;
    logic [`IV_W-1:0] init_value;
  } ksg_load_t;
endpackage

// File: src/word_skid_buffer.sv
// two-entry valid/ready buffer for slot words
// assumes one clock, active low async reset
`timescale 1ns/1ps
module word_skid_buffer #(
  parameter int W = 10
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  // elaboration guard: a zero-width word has nothing to carry
  if (W < 1)
  begin : g_bad_width
    $error("buffer word width must be at least one");
  end
  logic [W-1:0] mem_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  wire push = enable && in_valid && in_ready;
  wire pop = enable && out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  always_ff @(posedge clock)
    if (push) mem_q[wr_q] <= in_data;
  AST_NO_OVERFLOW: assert property (@(posedge clock) disable iff (!nrst)
    cnt_q != 2'h3) else $error("buffer count out of range");
endmodule // word_skid_buffer

// File: src/segment_splitter.sv
// counts keystream bits of a frame pair into tail, payload and segment
// assumes the generator streams one bit per accepted cycle
`timescale 1ns/1ps
module segment_splitter (
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  input wire logic restart,
  input wire logic ks_valid,
  output logic in_second,
  output logic in_tail,
  output logic pair_done
);
  logic [9:0] pos_q;
  assign in_second = pos_q >= 10'(`SEG_BITS);
  assign in_tail = (in_second ? pos_q - 10'(`SEG_BITS) : pos_q)
    < 10'(`TAIL_BITS);
  assign pair_done = pos_q == 10'(`PAIR_BITS);
  always_ff @(posedge clock or negedge nrst)
    if (!nrst) pos_q <= 10'h000;
    else if (enable)
    begin
      if (restart) pos_q <= 10'h000;
      else if (ks_valid && !pair_done) pos_q <= pos_q + 10'h001;
    end
endmodule // segment_splitter

// File: test/fixed_end_model.sv
// fixed end model: answers mode switch requests in odd frames
// assumes frame_start and frame_num are shared with the portable end
`timescale 1ns/1ps
`include "cipher_ctl_regs.svh"
module fixed_end_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic frame_start,
  input wire logic [`IV_FRAME_W-1:0] frame_num,
  input wire logic [`MSG_W-1:0] tx_tail_msg,
  input wire logic mute,
  output logic [`MSG_W-1:0] rx_tail_msg,
  output logic rx_tail_valid
);
  logic pend_q;
  logic [3:0] left_q;
  logic [`MSG_W-1:0] code_q;
  logic [2:0] wait_q;
  logic [`MSG_W-1:0] noise_q;
  // the message of the even frame just ended is still on tx_tail_msg
  wire odd_start = frame_start && frame_num[0];
  wire is_req = (tx_tail_msg == `MSG_ON_REQ) || (tx_tail_msg == `MSG_OFF_REQ);
  wire is_grant = (tx_tail_msg == `MSG_ON_GRANT) ||
                  (tx_tail_msg == `MSG_OFF_GRANT);
  wire fresh = odd_start && is_req && !pend_q;
  wire again = odd_start && pend_q && !is_grant && (left_q != 4'h0);
  // a muted link keeps its state but loses every confirm
  wire send = (fresh || again) && !mute;
  wire [2:0] wait_d = send ? 3'h4 : (wait_q != 3'h0 ? wait_q - 3'h1 : 3'h0);
  wire drop = odd_start && (is_grant || (pend_q && left_q == 4'h0));

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pend_q <= 1'b0;
      left_q <= 4'h0;
      code_q <= `MSG_NONE;
      wait_q <= 3'h0;
      noise_q <= 3'h5;
      rx_tail_valid <= 1'b0;
    end
    else
    begin
      noise_q <= noise_q + 3'h3;
      if (drop)
        pend_q <= 1'b0;
      else if (fresh)
      begin
        pend_q <= 1'b1;
        left_q <= 4'h5;
        code_q <= (tx_tail_msg == `MSG_ON_REQ) ? `MSG_ON_CONF : `MSG_OFF_CONF;
      end
      else if (again)
        left_q <= left_q - 4'h1;
      wait_q <= wait_d;
      rx_tail_valid <= (wait_q == 3'h1);
    end
  end

  // idle tail lines wander so a stale code is never read as fresh
  assign rx_tail_msg = rx_tail_valid ? code_q : noise_q;
endmodule // fixed_end_model

// File: test/air_cipher_mode_control_test.sv
// bench for the portable-end cipher mode controller
// assumes the fixed end model answers on the shared frame timing
`timescale 1ns/1ps
`include "cipher_ctl_regs.svh"
module air_cipher_mode_control_test;
  localparam int FRAME = 20;
  logic clock, nrst, enable, frame_start, req, mute, ks_bit, ks_valid;
  logic cfm, disc, cmode, ld_valid, ks_ready, rx_in_ready, tx_in_ready;
  logic rx_out_valid, tx_out_valid, rx_in_valid, tx_in_valid;
  logic rx_out_ready, tx_out_ready, rx_tail_valid, is_ct;
  logic [`KEY_W-1:0] key;
  logic [`IV_FRAME_W-1:0] fnum;
  logic [`IV_MFRAME_W-1:0] mfnum;
  logic [`MSG_W-1:0] tx_msg, rx_msg;
  cipher_ctl_pkg::ksg_load_t ld, last_ld;
  cipher_ctl_pkg::slot_word_t rx_in, tx_in, rx_out, tx_out;
  int num_errors, compares, cycles, n_cfm, n_disc, n_ld, fcnt;
  int msg_cnt [8];

  portable_cipher_ctl u_dut (.clock(clock), .nrst(nrst), .enable(enable),
    .cipher_key(key), .frame_start(frame_start), .frame_num(fnum),
    .mframe_num(mfnum), .switch_mode_request(req),
    .switch_mode_confirm(cfm), .disconnect_indication(disc),
    .cipher_mode(cmode), .tx_tail_msg(tx_msg), .rx_tail_msg(rx_msg),
    .rx_tail_valid(rx_tail_valid), .ksg_load(ld), .ksg_load_valid(ld_valid),
    .ks_bit(ks_bit), .ks_valid(ks_valid), .ks_ready(ks_ready),
    .rx_is_ct(is_ct), .tx_is_ct(is_ct), .rx_in(rx_in),
    .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready), .rx_out(rx_out),
    .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready), .tx_in(tx_in),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_out(tx_out),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready));

  fixed_end_model u_fixed (.clock(clock), .nrst(nrst),
    .frame_start(frame_start), .frame_num(fnum), .tx_tail_msg(tx_msg),
    .mute(mute), .rx_tail_msg(rx_msg), .rx_tail_valid(rx_tail_valid));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ceiling is several times the expected run of about 700 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cfm === 1'b1) n_cfm++;
    if (disc === 1'b1) n_disc++;
    if (ld_valid === 1'b1)
    begin
      n_ld++;
      last_ld = ld;
    end
    if (cycles == 6000)
    begin
      num_errors++;
      stop_test();
    end
  end

  // frame timing; the ending frame's tail message is tallied here
  always @(posedge clock)
  begin
    #1;
    frame_start = 1'b0;
    if (nrst === 1'b1)
    begin
      fcnt++;
      if (fcnt == FRAME)
      begin
        fcnt = 0;
        if (tx_msg !== `MSG_NONE)
          chk_vec("message frame parity", 64'h0, 64'(fnum[0]));
        msg_cnt[tx_msg]++;
        {mfnum, fnum} = {mfnum, fnum} + 28'h1;
        frame_start = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_vec(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic wait_frames(input int n);
    repeat (n) @(posedge frame_start);
  endtask

  task automatic pulse_req();
    @(posedge clock);
    #1 req = 1'b1;
    @(posedge clock);
    #1 req = 1'b0;
  endtask

  task automatic set_in(input bit tx, input logic v, input logic [7:0] d);
    if (tx)
    begin
      tx_in = {d, 2'b00};
      tx_in_valid = v;
    end
    else
    begin
      rx_in = {d, 2'b00};
      rx_in_valid = v;
    end
  endtask

  // one receive word through the keystream path, judged at the output
  task automatic send_rx(input logic [7:0] d, input logic [7:0] exp_d,
                         input logic exp_drop);
    @(posedge clock);
    #1 set_in(1'b0, 1'b1, d);
    #1;
    chk_bit("receive ready", 1'b1, rx_in_ready);
    chk_bit("key bit taken", 1'b1, ks_ready);
    @(posedge clock);
    #1 set_in(1'b0, 1'b0, 8'h00);
    chk_bit("received valid", 1'b1, rx_out_valid);
    chk_vec("received word", 64'(exp_d), 64'(rx_out.data));
    chk_bit("received drop", exp_drop, rx_out.discard);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_bit("cipher mode", 1'b0, cmode);
    chk_vec("tail message", 64'(`MSG_NONE), 64'(tx_msg));
    chk_bit("disconnect", 1'b0, disc);
    $display("test reset done");
  endtask

  // clear mode: keystream offered but words must pass untouched
  task automatic t_buffer(input bit tx);
    int acc;
    int got;
    acc = 0;
    got = 0;
    @(posedge clock);
    #1;
    rx_out_ready = 1'b0;
    tx_out_ready = 1'b0;
    set_in(tx, 1'b1, 8'hA0);
    repeat (8)
    begin
      @(posedge clock);
      if ((tx ? tx_in_ready : rx_in_ready) === 1'b1)
        acc++;
      #1 set_in(tx, 1'b1, 8'hA0 + 8'(acc));
    end
    chk_bit("ready when full", 1'b0, tx ? tx_in_ready : rx_in_ready);
    chk_vec("words held", 64'h2, 64'(acc));
    @(posedge clock);
    #1 set_in(tx, 1'b0, 8'h00);
    rx_out_ready = 1'b1;
    tx_out_ready = 1'b1;
    repeat (12)
    begin
      @(posedge clock);
      if ((tx ? tx_out_valid : rx_out_valid) === 1'b1)
      begin
        chk_vec("word out", 64'(8'hA0 + 8'(got)),
                64'(tx ? tx_out.data : rx_out.data));
        got++;
      end
    end
    chk_vec("words drained", 64'(acc), 64'(got));
    $display("test buffer done");
  endtask

  task automatic t_ksg(input bit exp_load);
    int n0;
    logic [`IV_W-1:0] iv;
    wait_frames(1);
    iv = {7'h00, mfnum, fnum};
    n0 = n_ld;
    repeat (3) @(posedge clock);
    chk_vec("generator loads", 64'(n0 + int'(exp_load)), 64'(n_ld));
    if (exp_load)
    begin
      chk_vec("load key", key, last_ld.cipher_key);
      chk_vec("load init value", 64'(iv), 64'(last_ld.init_value));
    end
    $display("test key load done");
  endtask

  task automatic t_switch(input string name, input logic [2:0] rq,
                          input logic [2:0] gr, input logic mode);
    int r0, g0, c0, k;
    r0 = msg_cnt[rq];
    g0 = msg_cnt[gr];
    c0 = n_cfm;
    pulse_req();
    for (k = 0; k < 6 * FRAME && n_cfm == c0; k++)
      @(posedge clock);
    wait_frames(3);
    chk_vec("confirm pulses", 64'(c0 + 1), 64'(n_cfm));
    chk_vec("request frames", 64'(r0 + 1), 64'(msg_cnt[rq]));
    chk_vec("grant frames", 64'(g0 + 1), 64'(msg_cnt[gr]));
    chk_bit("cipher mode", mode, cmode);
    $display("test %s done", name);
  endtask

  // tail bit of the first segment is ciphered only for control data
  task automatic t_cipher(input logic ct);
    wait_frames(1);
    is_ct = ct;
    send_rx(8'h3C, 8'h3C ^ 8'(ct), 1'b0);
    $display("test cipher done");
  endtask

  task automatic t_timeout();
    int r0, d0;
    mute = 1'b1;
    r0 = msg_cnt[`MSG_ON_REQ];
    d0 = n_disc;
    pulse_req();
    wait_frames(4);
    send_rx(8'h5A, 8'h5A, 1'b1);
    wait_frames(10);
    chk_vec("tries", 64'(r0 + 5), 64'(msg_cnt[`MSG_ON_REQ]));
    chk_vec("disconnects", 64'(d0 + 1), 64'(n_disc));
    chk_bit("cipher mode", 1'b0, cmode);
    pulse_req();
    wait_frames(4);
    chk_vec("late tries", 64'(r0 + 5), 64'(msg_cnt[`MSG_ON_REQ]));
    $display("test timeout done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    enable = 1'b1;
    frame_start = 1'b0;
    req = 1'b0;
    mute = 1'b0;
    is_ct = 1'b0;
    key = 64'h0F1E2D3C4B5A6978;
    fnum = 4'h0;
    mfnum = 24'h5A3C1E;
    ks_bit = 1'b1;
    ks_valid = 1'b1;
    rx_in = '0;
    tx_in = '0;
    rx_in_valid = 1'b0;
    tx_in_valid = 1'b0;
    rx_out_ready = 1'b1;
    tx_out_ready = 1'b1;
    {num_errors, compares, cycles, n_cfm, n_disc, n_ld, fcnt} = '0;
    msg_cnt = '{default: 0};
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    t_reset();
    t_buffer(1'b0);
    t_buffer(1'b1);
    t_ksg(1'b0);
    key = 64'hC3D2E1F00F1E2D3C;
    t_switch("start", `MSG_ON_REQ, `MSG_ON_GRANT, 1'b1);
    t_ksg(1'b1);
    t_cipher(1'b0);
    t_cipher(1'b1);
    t_switch("stop", `MSG_OFF_REQ, `MSG_OFF_GRANT, 1'b0);
    t_ksg(1'b0);
    t_timeout();
    stop_test();
  end
endmodule // air_cipher_mode_control_test
